// *** hdl/wtb_top.sv ***
// watchdog timer block: registers, down counter and interrupt routing
module wtb_top
  import wtb_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        joy_access_i,
  input  wire logic        kbd_irq_i,
  input  wire logic        mouse_irq_i,
  input  wire logic        kbc_force_line_i,
  output logic      [15:0] host_irq_o,
  output logic             irq_o
);
  wtb_tick_if tk ();

  // software-visible state
  logic       sec_ff, nxt_sec;
  logic [7:0] value_ff, nxt_value;
  logic [7:0] cfg_ff, nxt_cfg;
  logic       stat_ff, nxt_stat;
  logic       kbc_en_ff, nxt_kbc_en;
  // counter state
  wtb_state_e st_ff, nxt_st;
  logic [7:0] cnt_ff, nxt_cnt;
  // interrupt and readback state
  logic [1:0]  istat_ff, nxt_istat;
  logic [1:0]  imask_ff, nxt_imask;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic [15:0] hirq_ff, nxt_hirq;
  logic        irq_ff, nxt_irq;

  logic       kbc_pulse;
  logic       force_sw;
  logic       force_ev;
  logic       value_wr;
  logic       restart;
  logic       expire;
  logic       timeout;
  logic       reload;
  logic [7:0] load_val;

  // event decode shared by every group
  always_comb begin
    value_wr = wr_i && addr_i == ADDR_VALUE;
    force_sw = wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_FORCE_BIT];
    force_ev = force_sw | kbc_pulse;
    restart  = (cfg_ff[CFG_JOY_BIT] & joy_access_i)
             | (cfg_ff[CFG_KBD_BIT] & kbd_irq_i)
             | (cfg_ff[CFG_MOUSE_BIT] & mouse_irq_i);
    expire   = st_ff == ST_COUNT && tk.tick && cnt_ff == 8'h01;
    timeout  = expire | force_ev;
    reload   = restart | value_wr;
    load_val = value_wr ? wdata_i : value_ff;
  end

  // register writes; reserved bits are dropped so they read as zero
  always_comb begin
    nxt_sec    = sec_ff;
    nxt_value  = value_ff;
    nxt_cfg    = cfg_ff;
    nxt_kbc_en = kbc_en_ff;
    nxt_stat   = stat_ff;
    if (wr_i) begin
      case (addr_i)
        ADDR_UNITS: nxt_sec = wdata_i[UNITS_SEC_BIT];
        ADDR_VALUE: nxt_value = wdata_i;
        ADDR_CFG: nxt_cfg = wdata_i & CFG_MASK;
        ADDR_CTRL: begin
          nxt_kbc_en = wdata_i[CTRL_KBC_BIT];
          nxt_stat   = wdata_i[CTRL_STAT_BIT];
        end
        default: ;
      endcase
    end
    // a fresh count means the timer is counting again
    if (reload) begin
      nxt_stat = 1'b0;
    end
    // time-out sets status, wins over clear
    if (timeout) begin
      nxt_stat = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sec_ff    <= 1'b0;
      value_ff  <= REG_RST;
      cfg_ff    <= REG_RST;
      kbc_en_ff <= 1'b0;
      stat_ff   <= 1'b0;
    end else begin
      sec_ff    <= nxt_sec;
      value_ff  <= nxt_value;
      cfg_ff    <= nxt_cfg;
      kbc_en_ff <= nxt_kbc_en;
      stat_ff   <= nxt_stat;
    end
  end

  // down counter; a force beats a restart in the same cycle
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    if (timeout) begin
      nxt_st  = ST_EXPIRED;
      nxt_cnt = 8'h00;
    end else if (reload) begin
      if (load_val == 8'h00) begin
        nxt_st  = ST_IDLE;
        nxt_cnt = 8'h00;
      end else begin
        nxt_st  = ST_COUNT;
        nxt_cnt = load_val;
      end
    end else begin
      case (st_ff)
        ST_COUNT: begin
          if (tk.tick) begin
            nxt_cnt = cnt_ff - 8'h01;
          end
        end
        ST_IDLE: ;
        ST_EXPIRED: ;
        default: begin
          nxt_st  = ST_IDLE;
          nxt_cnt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_ff  <= ST_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // prescaler held clear outside counting so each load starts a full unit
  assign tk.clr      = timeout | reload | (st_ff != ST_COUNT);
  assign tk.sec_unit = sec_ff;

  wtb_ticker #(
    .SEC_CYC (SEC_CYC)
  ) u_ticker (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tk     (tk)
  );

  wtb_edge u_edge (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .line_i  (kbc_force_line_i),
    .en_i    (kbc_en_ff),
    .pulse_o (kbc_pulse)
  );

  // readback, sticky events and interrupt outputs
  always_comb begin
    nxt_imask = imask_ff;
    nxt_istat = istat_ff;
    nxt_rdata = 8'h00;
    if (wr_i && addr_i == ADDR_IMASK) begin
      nxt_imask = wdata_i[1:0];
    end
    if (rd_i) begin
      case (addr_i)
        ADDR_UNITS: nxt_rdata[UNITS_SEC_BIT] = sec_ff;
        ADDR_VALUE: nxt_rdata = value_ff;
        ADDR_CFG:   nxt_rdata = cfg_ff;
        ADDR_CTRL: begin
          nxt_rdata[CTRL_STAT_BIT] = stat_ff;
          nxt_rdata[CTRL_KBC_BIT]  = kbc_en_ff;
        end
        ADDR_ISTAT: begin
          nxt_rdata[1:0] = istat_ff;
          nxt_istat      = 2'h0;
        end
        ADDR_IMASK: nxt_rdata[1:0] = imask_ff;
        default: ;
      endcase
    end
    // events set after the read clear, so none is lost
    if (timeout) begin
      nxt_istat[IEV_TIMEOUT] = 1'b1;
    end
    if (reload) begin
      nxt_istat[IEV_RESTART] = 1'b1;
    end
    nxt_hirq = nxt_stat ? wtb_irq_decode(nxt_cfg[7:CFG_MAP_LSB])
                        : 16'h0000;
    nxt_irq  = |(nxt_istat & nxt_imask);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      imask_ff <= 2'h0;
      istat_ff <= 2'h0;
      rdata_ff <= 8'h00;
      hirq_ff  <= 16'h0000;
      irq_ff   <= 1'b0;
    end else begin
      imask_ff <= nxt_imask;
      istat_ff <= nxt_istat;
      rdata_ff <= nxt_rdata;
      hirq_ff  <= nxt_hirq;
      irq_ff   <= nxt_irq;
    end
  end

  assign rdata_o    = rdata_ff;
  assign host_irq_o = hirq_ff;
  assign irq_o      = irq_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence quiet_s;
    !timeout && !reload;
  endsequence

  zero_disables_a: assert property (
    value_wr && wdata_i == 8'h00 && !timeout
      |=> st_ff == ST_IDLE && !stat_ff ##1 !expire)
    else $error("zero value did not disable the time-out");

  load_value_a: assert property (
    reload && !timeout && load_val != 8'h00
      |=> st_ff == ST_COUNT && cnt_ff == $past(load_val))
    else $error("count not loaded with programmed value");

  joy_restart_a: assert property (
    joy_access_i && !timeout |-> restart == cfg_ff[CFG_JOY_BIT]
      || kbd_irq_i || mouse_irq_i)
    else $error("joystick access restart gating wrong");

  kbd_restart_a: assert property (
    kbd_irq_i && cfg_ff[CFG_KBD_BIT] && !timeout && value_ff != 8'h00
      && !value_wr |=> cnt_ff == $past(value_ff))
    else $error("keyboard interrupt did not restart");

  mouse_restart_a: assert property (
    mouse_irq_i && !cfg_ff[CFG_MOUSE_BIT] && !joy_access_i
      && !kbd_irq_i && !value_wr |-> !reload)
    else $error("disabled mouse interrupt restarted the count");

  irq_map_a: assert property (
    host_irq_o != 16'h0000 |-> stat_ff && $onehot(host_irq_o)
      && cfg_ff[7:CFG_MAP_LSB] != MAP_INVALID)
    else $error("host interrupt line wrong");

  status_set_a: assert property (
    timeout |=> stat_ff && st_ff == ST_EXPIRED && cnt_ff == 8'h00)
    else $error("time-out did not set status");

  force_clear_a: assert property (
    force_sw ##1 (!reload && !(wr_i && addr_i == ADDR_CTRL))
      ##1 (rd_i && addr_i == ADDR_CTRL)
      |=> rdata_o[CTRL_FORCE_BIT] == 1'b0 && rdata_o[CTRL_STAT_BIT])
    else $error("force bit not self-clearing");

  kbc_gate_a: assert property (
    kbc_pulse |-> $past(kbc_en_ff) ##1 stat_ff)
    else $error("keyboard line force not gated or lost");

  count_down_a: assert property (
    (st_ff == ST_COUNT && tk.tick && cnt_ff > 8'h01) and quiet_s
      |=> cnt_ff == $past(cnt_ff) - 8'h01)
    else $error("counter did not step once per unit");

  joy_reload_a: assert property (
    joy_access_i && cfg_ff[CFG_JOY_BIT] && !timeout && !value_wr
      && value_ff != 8'h00
      |=> st_ff == ST_COUNT && cnt_ff == $past(value_ff))
    else $error("joystick access did not restart");

  force_wins_a: assert property (
    force_sw |=> st_ff == ST_EXPIRED && stat_ff
      && host_irq_o == wtb_irq_decode(cfg_ff[7:CFG_MAP_LSB]))
    else $error("forced time-out lost to another event");

  istat_clear_a: assert property (
    rd_i && addr_i == ADDR_ISTAT && !timeout && !reload
      |=> istat_ff == 2'h0 && !irq_o)
    else $error("event status not cleared by its read");

  held_line_a: assert property (
    kbc_force_line_i && $past(kbc_force_line_i) |=> !kbc_pulse)
    else $error("held keyboard line forced again");

  irq_level_a: assert property (
    irq_o |-> (istat_ff & imask_ff) != 2'h0)
    else $error("interrupt high with no unmasked status");
endmodule // wtb_top

// *** hdl/wtb_pkg.sv ***
// constants, offsets and decode helpers for the watchdog timer block
// What this block does
// - units bit 7: minutes zero, seconds one
// - timeout value zero disables the time-out
// - value N gives N units time-out
// - config bit 0: joystick access restarts
// - config bit 1: keyboard interrupt restarts
// - config bit 2: mouse interrupt restarts
// - config bits 7:4 pick host interrupt
// - control bit 0 shows time-out occurred
// - control bit 2 forces time-out, self-clears
// - control bit 3 lets keyboard line force
// - keyboard line rising edge only, ORed
package wtb_pkg;
  // register addresses on the plain register port
  localparam logic [7:0] ADDR_UNITS = 8'h52;
  localparam logic [7:0] ADDR_VALUE = 8'h53;
  localparam logic [7:0] ADDR_CFG   = 8'h54;
  localparam logic [7:0] ADDR_CTRL  = 8'h55;
  localparam logic [7:0] ADDR_ISTAT = 8'h60;
  localparam logic [7:0] ADDR_IMASK = 8'h61;
  // field positions
  localparam int UNITS_SEC_BIT = 7;
  localparam int CFG_JOY_BIT   = 0;
  localparam int CFG_KBD_BIT   = 1;
  localparam int CFG_MOUSE_BIT = 2;
  localparam int CFG_MAP_LSB   = 4;
  localparam int CTRL_STAT_BIT = 0;
  localparam int CTRL_FORCE_BIT = 2;
  localparam int CTRL_KBC_BIT  = 3;
  localparam int IEV_TIMEOUT   = 0;
  localparam int IEV_RESTART   = 1;
  // reset values and writable-bit masks
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [7:0] CFG_MASK = 8'hF7;
  localparam logic [3:0] MAP_OFF     = 4'h0;
  localparam logic [3:0] MAP_INVALID = 4'h2;
  // timing: 10 MHz clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam int SECS_PER_MIN  = 60;
  localparam int PRE_W = 24;
  localparam int MIN_W = 6;

  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_EXPIRED} wtb_state_e;

  // one-hot host interrupt line from the mapping code
  function automatic logic [15:0] wtb_irq_decode(input logic [3:0] code);
    logic [15:0] res;
    res = 16'h0000;
    if (code != MAP_OFF && code != MAP_INVALID) begin
      res[code] = 1'b1;
    end
    return res;
  endfunction
endpackage

// *** hdl/wtb_tick_if.sv ***
// unit tick handshake between the timer and its prescaler
interface wtb_tick_if;
  logic clr;
  logic sec_unit;
  logic tick;
  modport timer  (output clr, output sec_unit, input tick);
  modport ticker (input clr, input sec_unit, output tick);
endinterface

// *** hdl/wtb_ticker.sv ***
// prescaler that emits one tick per second or per minute
module wtb_ticker
  import wtb_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  wtb_tick_if.ticker tk
);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SEC_CYC - 1);
  localparam logic [MIN_W-1:0] MIN_LAST = MIN_W'(SECS_PER_MIN - 1);

  logic [PRE_W-1:0] pre_ff, nxt_pre;
  logic [MIN_W-1:0] min_ff, nxt_min;
  logic             tick_ff, nxt_tick;
  logic             sec_end;

  // clear restarts a whole unit, so a reload always waits N full units
  always_comb begin
    sec_end  = (pre_ff == PRE_LAST);
    nxt_pre  = sec_end ? '0 : pre_ff + 1'b1;
    nxt_min  = min_ff;
    nxt_tick = 1'b0;
    if (sec_end) begin
      if (tk.sec_unit) begin
        nxt_tick = 1'b1;
      end else if (min_ff == MIN_LAST) begin
        nxt_min  = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_min = min_ff + 1'b1;
      end
    end
    if (tk.clr) begin
      nxt_pre  = '0;
      nxt_min  = '0;
      nxt_tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pre_ff  <= '0;
      min_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= nxt_pre;
      min_ff  <= nxt_min;
      tick_ff <= nxt_tick;
    end
  end

  assign tk.tick = tick_ff;

  unit_tick_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_ff |-> $past(pre_ff) == PRE_LAST
      && ($past(tk.sec_unit) || $past(min_ff) == MIN_LAST))
    else $error("unit tick without a full unit");
endmodule // wtb_ticker

// *** hdl/wtb_edge.sv ***
// rising edge of the keyboard controller line to a one-cycle pulse
module wtb_edge (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic line_i,
  input  wire logic en_i,
  output logic      pulse_o
);
  logic prev_ff, nxt_prev;
  logic pulse_ff, nxt_pulse;

  // edge only
  // a line held high for ever must not keep forcing time-outs
  always_comb begin
    nxt_prev  = line_i;
    nxt_pulse = en_i & line_i & ~prev_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prev_ff  <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      prev_ff  <= nxt_prev;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse_o = pulse_ff;

  kbc_edge_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pulse_ff |-> $past(line_i) && $past(en_i) && !$past(prev_ff)
      ##1 !pulse_ff)
    else $error("keyboard line pulse not a single rising edge");
endmodule // wtb_edge

// *** bench/wtb_partner.sv ***
// far-side model: restart event sources and keyboard controller line
module wtb_partner (
  input  wire logic clk_i,
  output logic      joy_o,
  output logic      kbd_o,
  output logic      mouse_o,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // all sources quiet from time zero
  initial begin
    joy_o   = 1'b0;
    kbd_o   = 1'b0;
    mouse_o = 1'b0;
    line_o  = 1'b0;
  end

  // one-cycle event on source k: 0 joystick, 1 keyboard, 2 mouse
  task automatic pulse(input int k);
    @(posedge clk_i);
    joy_o   <= (k == 0);
    kbd_o   <= (k == 1);
    mouse_o <= (k == 2);
    @(posedge clk_i);
    joy_o   <= 1'b0;
    kbd_o   <= 1'b0;
    mouse_o <= 1'b0;
    // step off the edge so the caller compares settled outputs
    #1;
  endtask

  // line may stay high for as long as asked
  task automatic set_line(input logic v);
    @(posedge clk_i);
    line_o <= v;
  endtask
endmodule // wtb_partner

// *** bench/tb_top.sv ***
// self-checking bench for the watchdog timer block
module tb_top
  import wtb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // short second keeps minute counts cheap to simulate
  localparam int SC = 10;

  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o;
  logic        joy, kbd, mouse, line;
  logic [15:0] host_irq_o;
  logic        irq_o;
  logic [7:0]  m [0:255];
  int          n_errors = 0;
  int          check_count = 0;
  int          seed = 65;
  int          n;

  always #50 clk_i = ~clk_i;

  wtb_top #(.SEC_CYC(SC)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .joy_access_i(joy),
    .kbd_irq_i(kbd), .mouse_irq_i(mouse), .kbc_force_line_i(line),
    .host_irq_o(host_irq_o), .irq_o(irq_o));

  wtb_partner partner_u (
    .clk_i(clk_i), .joy_o(joy), .kbd_o(kbd), .mouse_o(mouse),
    .line_o(line));

  // writable bits of each register; force bit never reads back
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      ADDR_UNITS: return 8'h80;
      ADDR_VALUE: return 8'hFF;
      ADDR_CFG:   return 8'hF7;
      ADDR_CTRL:  return 8'h09;
      ADDR_IMASK: return 8'h03;
      default:    return 8'h00;
    endcase
  endfunction

  // one line per code, none for off and invalid
  function automatic logic [15:0] exp_host();
    logic [3:0] c;
    c = m[ADDR_CFG][7:4];
    if (m[ADDR_CTRL][0] && c != 4'h0 && c != 4'h2) return 16'h0001 << c;
    return 16'h0000;
  endfunction

  task automatic expire();
    m[ADDR_CTRL][0] = 1'b1;
    m[ADDR_ISTAT][0] = 1'b1;
  endtask

  task automatic restart();
    m[ADDR_CTRL][0] = 1'b0;
    m[ADDR_ISTAT][1] = 1'b1;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected host_irq_o exp %h got %h", e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected irq_o exp %b got %b", e, g);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask

  task automatic chk();
    chk16(exp_host(), host_irq_o);
    chk1(|(m[ADDR_ISTAT] & m[ADDR_IMASK]), irq_o);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a != ADDR_ISTAT) m[a] = d & wmask(a);
    if (a == ADDR_VALUE) restart();
    // force raises the flag at once
    if (a == ADDR_CTRL && d[2]) expire();
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk8("rdata_o", m[a], rdata_o);
    if (a == ADDR_ISTAT) m[a] = 8'h00;
  endtask

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end

  initial begin
    for (int i = 0; i < 256; i++) m[i] = 8'h00;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    // reset values, unmapped place reads zero
    foreach (m[i]) if (wmask(8'(i)) != 8'h00 || i == 8'h70) rd(8'(i));
    rd(ADDR_ISTAT);
    wr(8'h70, 8'hFF);
    rd(8'h70);
    // minutes by default: one unit is sixty seconds
    wr(ADDR_IMASK, 8'h01);
    wr(ADDR_CFG, 8'h30);
    wr(ADDR_VALUE, 8'h01);
    wt(60 * SC - 4);
    chk();
    wt(8);
    expire();
    chk();
    rd(ADDR_CTRL);
    rd(ADDR_ISTAT);
    rd(ADDR_ISTAT);
    chk();
    // reserved units bits written as zero
    wr(ADDR_UNITS, 8'h80);
    n = 1 + ($random(seed) & 3);
    wr(ADDR_VALUE, 8'(n));
    wt(n * SC - 4);
    chk();
    wt(8);
    expire();
    chk();
    // each enabled source holds the timer off, disabled ones do not
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CFG, 8'h30 | (8'h01 << k));
      wr(ADDR_VALUE, 8'h02);
      repeat (4) begin
        wt(14);
        partner_u.pulse(k);
        restart();
        chk();
      end
      wr(ADDR_CFG, 8'h30);
      wt(2);
      partner_u.pulse(k);
      wt(19);
      expire();
      chk();
      rd(ADDR_ISTAT);
    end
    wr(ADDR_VALUE, 8'h00);
    wt(5 * SC);
    chk();
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_CTRL);
    chk();
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CFG, 8'(c << 4));
      wt(2);
      chk();
    end
    wr(ADDR_CFG, 8'h30);
    wr(ADDR_CTRL, 8'h00);
    partner_u.set_line(1'b1);
    wt(5);
    chk();
    partner_u.set_line(1'b0);
    wr(ADDR_CTRL, 8'h08);
    partner_u.set_line(1'b1);
    wt(4);
    expire();
    chk();
    wr(ADDR_CTRL, 8'h08);
    wt(10);
    chk();
    rd(ADDR_CTRL);
    partner_u.set_line(1'b0);
    rd(ADDR_ISTAT);
    wt(2);
    chk();
    complete_run();
  end
endmodule // tb_top
